// file: bench/pump_plant.sv
// pump motor and process sensor model at the controller's far side
`default_nettype none
module pump_plant
	import sleep_wake_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             stop,
	input  wire logic [VAL_W-1:0] override,
	input  wire logic             spin,
	input  wire process_t         scene,
	output process_t              sensed,
	output logic                  running
);
	timeunit 1ns;
	timeprecision 1ns;
	// sensors lag one tick, so the controller never sees a change in the edge that makes it
	always_ff @(posedge clk) begin
		running <= spin && !stop;
		sensed <= scene;
		if (stop)
			sensed.speed <= '0;
		else if (override != '0)
			sensed.speed <= override;
	end
endmodule
`default_nettype wire

// file: bench/sleep_wake_ctrl_tb.sv
// self-checking bench for the pump sleep/wake controller
`default_nettype none
module sleep_wake_ctrl_tb
	import sleep_wake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SD = 5;
	localparam int WD = 4;
	logic clk = 1'b0, rst = 1'b1, run = 1'b0, am = 1'b1, mp = 1'b0, fc = 1'b0;
	logic aux = 1'b1, inv = 1'b0, spin = 1'b0, ce = 1'b1, mr, lp, bo, sl, ms;
	logic [4:0] crit = 5'h00;
	logic [5:0] src = 6'h00, di = 6'h00, ex = 6'h00;
	logic [2:0] bus = 3'h2;
	logic [79:0] cmd = 80'h0;
	logic [15:0] bt = 16'h0003, so;
	sleep_detect_t det = DETECT_NONE;
	wake_mode_t wm = WAKE_FEEDBACK;
	process_t sc = {16'h00C8, 16'h0064, 16'h0190, 16'h01F4, 16'h0258, 16'h02BC};
	process_t ps;
	int fails = 0, checks = 0;
	sleep_detect_t dets [9] = '{DETECT_SWITCH, DETECT_SWITCH, DETECT_SWITCH, DETECT_SWITCH,
		DETECT_FLOW, DETECT_SPEED, DETECT_POWER, DETECT_PRESSURE, DETECT_MULTIPLE};
	logic [5:0] srcs [9] = '{6'h01, 6'h07, 6'h0D, 6'h22, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
	logic [3:0] st;
	assign st = {lp, bo, sl, ms};
	always #50 clk = ~clk;
	pump_plant plant (.clk(clk), .stop(ms), .override(so), .spin(spin), .scene(sc),
		.sensed(ps), .running(mr));
	sleep_wake_ctrl dut (.MCLK(clk), .RST(rst), .CE(ce), .RUN_ORDER(run), .AUTO_MODE(am),
		.MOTOR_RUNNING(mr), .MULTI_PUMP(mp), .FLOW_CONTROL(fc), .AUX_PUMPS_STOPPED(aux),
		.LOOP_INVERSION(inv), .SLEEP_DETECT_SELECT(det), .LOW_FLOW_CRITERION(crit[0]),
		.SPEED_CRITERION(crit[1]), .POWER_CRITERION(crit[2]),
		.HIGH_PRESSURE_CRITERION(crit[3]), .SWITCH_CRITERION(crit[4]),
		.WAKE_MODE_SELECT(wm), .SLEEP_SWITCH_SOURCE(src), .SWITCH_BUS_SELECT(bus),
		.DIGITAL_IN(di), .EXTENSION_IN(ex), .COMMAND_BITS(cmd), .PROCESS(ps),
		.LEVELS({16'h0064, 16'h00C8, 16'h012C, 16'h0190, 16'h01F4, 16'h0032}),
		.SLEEP_QUALIFY_DELAY(16'h0005), .WAKE_QUALIFY_DELAY(16'h0004),
		.SLEEP_BOOST_SPEED(16'h0123), .SLEEP_BOOST_TIME(bt), .LOOP_ACTIVE(lp),
		.BOOST_ACTIVE(bo), .ASLEEP(sl), .MOTOR_STOP(ms), .SPEED_OVERRIDE(so));
	// ----------------
	// helpers
	// ----------------
	task results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cmp(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task look(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wait_st(input logic [3:0] e, output int n);
		// step off the edge so the first look sees settled outputs
		#1;
		for (n = 0; n < 40 && st !== e; n++)
			look(1);
		if (st !== e) begin
			fails++;
			results();
		end
	endtask
	// pressure mode still compares feedback; the pressure sensor is made to follow feedback there too
	task fb(input logic [15:0] v);
		sc.feedback <= v;
		if (wm == WAKE_PRESSURE)
			sc.pressure <= v;
	endtask
	// a turning motor is handed over by switching into auto, not by a fresh run order
	task restart(input logic [15:0] v, input logic turning);
		@(posedge clk);
		if (turning)
			am <= 1'b0;
		else
			run <= 1'b0;
		spin <= turning;
		fb(v);
		look(3);
		@(posedge clk);
		run <= 1'b1;
		am <= 1'b1;
		look(2);
	endtask
	// ----------------
	// scenarios
	// ----------------
	task wake_case(input wake_mode_t m, input logic iv, input logic [15:0] off, on);
		int n;
		@(posedge clk);
		wm <= m;
		inv <= iv;
		restart(off, 1'b0);
		cmp(16'(st), 16'h0003);
		@(posedge clk);
		fb(on);
		look(3);
		@(posedge clk);
		fb(off);
		look(1);
		@(posedge clk);
		fb(on);
		wait_st(4'h8, n);
		cmp(16'(n > WD + 1 && n < WD + 6), 16'h0001);
		restart(on, 1'b0);
		cmp(16'(st), 16'h0008);
	endtask
	task sleep_case(input int k);
		int n;
		@(posedge clk);
		det <= dets[k];
		src <= srcs[k];
		di <= {k != 3, 4'h0, k == 0};
		ex <= {5'h00, k == 1};
		cmd <= {47'h0, k == 2, 32'h0};
		crit <= {5{k == 8}};
		sc.flow <= k == 4 ? 16'h0032 : 16'h00C8;
		sc.speed <= k == 5 ? 16'h00FA : 16'h0190;
		sc.power <= (k == 6 || k == 8) ? 16'h0064 : 16'h01F4;
		sc.pressure <= k == 7 ? 16'h012C : 16'h0064;
		restart(16'h0190, 1'b0);
		cmp(16'(st), 16'h0008);
		look(SD + 4);
		cmp(16'(st), 16'h0008);
		@(posedge clk);
		fb(16'h0258);
		wait_st(4'h4, n);
		cmp(16'(n > SD + 1 && n < SD + 6), 16'h0001);
		cmp(so, 16'h0123);
		// a low enable must hold the boost phase where it is
		@(posedge clk);
		ce <= 1'b0;
		look(3);
		cmp(16'(st), 16'h0004);
		@(posedge clk);
		ce <= 1'b1;
		look(4);
		cmp(16'(st), 16'h0003);
		cmp(so, 16'h0000);
	endtask
	task multi_case;
		int n;
		@(posedge clk);
		det <= DETECT_FLOW;
		sc.flow <= 16'h0032;
		mp <= 1'b1;
		aux <= 1'b0;
		bt <= 16'h0000;
		restart(16'h0258, 1'b1);
		cmp(16'(st), 16'h0008);
		look(SD + 6);
		cmp(16'(st), 16'h0008);
		@(posedge clk);
		fc <= 1'b1;
		for (n = 0; n < 20 && st === 4'h8; n++)
			look(1);
		cmp(16'(st), 16'h0003);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wake_case(WAKE_FEEDBACK, 1'b0, 16'h0258, 16'h0190);
		wake_case(WAKE_FEEDBACK, 1'b1, 16'h0190, 16'h0258);
		wake_case(WAKE_ERROR, 1'b0, 16'h0294, 16'h0258);
		wake_case(WAKE_ERROR, 1'b1, 16'h02BC, 16'h0320);
		wake_case(WAKE_PRESSURE, 1'b1, 16'h0258, 16'h0190);
		@(posedge clk);
		wm <= WAKE_FEEDBACK;
		inv <= 1'b0;
		for (int k = 0; k < 9; k++)
			sleep_case(k);
		multi_case();
		results();
	end
endmodule
bind sleep_wake_ctrl sleep_wake_properties chk (.MCLK, .RST, .CE, .RUN_ORDER, .AUTO_MODE,
	.SLEEP_QUALIFY_DELAY, .WAKE_QUALIFY_DELAY, .SLEEP_BOOST_SPEED, .SLEEP_BOOST_TIME,
	.LOOP_ACTIVE, .BOOST_ACTIVE, .ASLEEP, .MOTOR_STOP, .SPEED_OVERRIDE);
`default_nettype wire

// file: bench/sleep_wake_properties.sv
// port checker for the pump sleep/wake controller
`default_nettype none
module sleep_wake_properties
	import sleep_wake_pkg::*;
(
	input wire logic             MCLK,
	input wire logic             RST,
	input wire logic             CE,
	input wire logic             RUN_ORDER,
	input wire logic             AUTO_MODE,
	input wire logic [DLY_W-1:0] SLEEP_QUALIFY_DELAY,
	input wire logic [DLY_W-1:0] WAKE_QUALIFY_DELAY,
	input wire logic [VAL_W-1:0] SLEEP_BOOST_SPEED,
	input wire logic [DLY_W-1:0] SLEEP_BOOST_TIME,
	input wire logic             LOOP_ACTIVE,
	input wire logic             BOOST_ACTIVE,
	input wire logic             ASLEEP,
	input wire logic             MOTOR_STOP,
	input wire logic [VAL_W-1:0] SPEED_OVERRIDE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// ----------------
	// dwell counters
	// ----------------
	// frozen with the clock enable, as the design's own timers are
	logic [DLY_W:0] run_len;
	logic [DLY_W:0] rest_len;
	logic [DLY_W:0] boost_len;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			run_len <= '0;
			rest_len <= '0;
			boost_len <= '0;
		end else if (CE) begin
			run_len <= LOOP_ACTIVE ? run_len + 1'b1 : '0;
			rest_len <= (BOOST_ACTIVE || ASLEEP) ? rest_len + 1'b1 : '0;
			boost_len <= BOOST_ACTIVE ? boost_len + 1'b1 : '0;
		end
	end
	sequence leave_run;
		LOOP_ACTIVE ##1 (BOOST_ACTIVE || ASLEEP);
	endsequence
	sequence leave_rest;
		(BOOST_ACTIVE || ASLEEP) ##1 LOOP_ACTIVE;
	endsequence
	sequence boost_end;
		BOOST_ACTIVE ##1 ASLEEP;
	endsequence
	sleep_dwell_a: assert property (leave_run |-> run_len > SLEEP_QUALIFY_DELAY)
		else $error("sleep entered before the sleep delay");
	wake_dwell_a: assert property (leave_rest |-> rest_len > WAKE_QUALIFY_DELAY)
		else $error("wake before the wake delay");
	boost_length_a: assert property (boost_end |-> boost_len == SLEEP_BOOST_TIME)
		else $error("boost phase length wrong");
	boost_skip_a: assert property (leave_run |-> BOOST_ACTIVE == (SLEEP_BOOST_TIME != 0))
		else $error("boost phase taken or skipped wrongly");
	idle_drop_a: assert property (!(RUN_ORDER && AUTO_MODE) && CE |=> !LOOP_ACTIVE && !ASLEEP)
		else $error("controller active without run order");
	start_state_a: assert property (!(LOOP_ACTIVE || BOOST_ACTIVE || ASLEEP) && RUN_ORDER
		&& AUTO_MODE && CE |=> (LOOP_ACTIVE ^ ASLEEP) && !BOOST_ACTIVE)
		else $error("bad state after run order");
	boost_speed_a: assert property (BOOST_ACTIVE |-> SPEED_OVERRIDE == SLEEP_BOOST_SPEED)
		else $error("boost speed wrong");
	halt_state_a: assert property (MOTOR_STOP == ASLEEP && (!ASLEEP || SPEED_OVERRIDE == 0))
		else $error("motor not halted in sleep");
	loop_free_a: assert property (LOOP_ACTIVE |-> SPEED_OVERRIDE == 0)
		else $error("speed override during closed loop");
endmodule
`default_nettype wire

// file: rtl/qualify_timer.sv
// qualification timer: condition must hold longer than a delay
`default_nettype none
module qualify_timer
	import sleep_wake_pkg::*;
#(
	parameter int W = DLY_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         cond,
	input  wire logic [W-1:0] delay,
	output logic              expired
);
	timer_t state;
	timer_t next_state;

	// counter saturates once past the delay so a long hold cannot wrap
	always_comb begin
		next_state = state;
		if (!cond) begin
			next_state.count = TIMER_RESET;
			next_state.done  = 1'b0;
		end else if (!state.done) begin
			if (state.count > delay[DLY_W-1:0])
				next_state.done = 1'b1;
			else
				next_state.count = state.count + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= '0;
		else if (ce)
			state <= next_state;
	end

	assign expired = state.done & cond;
endmodule
`default_nettype wire

// file: rtl/sleep_wake_ctrl.sv
// pump sleep/wake state controller
`default_nettype none
// Summary of operation
// - with no wake condition, sleep once chosen condition holds longer than sleep delay
// - multi-pump without flow control also needs every auxiliary pump stopped
// - detect selector: none, switch, flow, speed, power, pressure, multiple-OR
// - flow criterion met while flow is below sleep flow level
// - switch criterion met while assigned sleep switch is active
// - speed criterion met while output frequency below sleep speed
// - power criterion met while output power below sleep power
// - pressure criterion met while outlet pressure above sleep pressure level
// - multiple mode: any one enabled criterion suffices
// - wake only after wake condition holds longer than wake delay
// - feedback mode, direct: wake when feedback below wake level
// - feedback mode, inverted: wake when feedback above wake level
// - error mode, direct: wake when feedback below reference minus error
// - error mode, inverted: wake when feedback above reference plus error
// - pressure mode: wake when pressure feedback below wake level
// - on sleep entry run boost speed for boost time, then stop
// - zero boost time skips boost and stops directly
// - run order in auto with wake met starts closed loop at once
// - run order in auto without wake met goes straight to sleep, no boost
// - switching to auto while running stays running in closed loop
// - switch source: none, digital, extension, command bits, inverted digital
module sleep_wake_ctrl
	import sleep_wake_pkg::*;
#(
	parameter int DI_COUNT  = DI_N,
	parameter int EXT_COUNT = EXT_N,
	parameter int CMD_COUNT = CMD_N,
	parameter int BUS_COUNT = BUS_N
) (
	input  wire logic                   MCLK,
	input  wire logic                   RST,
	input  wire logic                   CE,
	input  wire logic                   RUN_ORDER,
	input  wire logic                   AUTO_MODE,
	input  wire logic                   MOTOR_RUNNING,
	input  wire logic                   MULTI_PUMP,
	input  wire logic                   FLOW_CONTROL,
	input  wire logic                   AUX_PUMPS_STOPPED,
	input  wire logic                   LOOP_INVERSION,
	input  wire sleep_detect_t          SLEEP_DETECT_SELECT,
	input  wire logic                   LOW_FLOW_CRITERION,
	input  wire logic                   SPEED_CRITERION,
	input  wire logic                   POWER_CRITERION,
	input  wire logic                   HIGH_PRESSURE_CRITERION,
	input  wire logic                   SWITCH_CRITERION,
	input  wire wake_mode_t             WAKE_MODE_SELECT,
	input  wire logic [SRC_W-1:0]       SLEEP_SWITCH_SOURCE,
	input  wire logic [2:0]             SWITCH_BUS_SELECT,
	input  wire logic [DI_COUNT-1:0]    DIGITAL_IN,
	input  wire logic [EXT_COUNT-1:0]   EXTENSION_IN,
	input  wire logic [BUS_COUNT*CMD_COUNT-1:0] COMMAND_BITS,
	input  wire process_t               PROCESS,
	input  wire levels_t                LEVELS,
	input  wire logic [DLY_W-1:0]       SLEEP_QUALIFY_DELAY,
	input  wire logic [DLY_W-1:0]       WAKE_QUALIFY_DELAY,
	input  wire logic [VAL_W-1:0]       SLEEP_BOOST_SPEED,
	input  wire logic [DLY_W-1:0]       SLEEP_BOOST_TIME,
	output logic                        LOOP_ACTIVE,
	output logic                        BOOST_ACTIVE,
	output logic                        ASLEEP,
	output logic                        MOTOR_STOP,
	output logic [VAL_W-1:0]            SPEED_OVERRIDE
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ctrl_state_t      mode;
		logic [DLY_W-1:0] boost_count;
		logic             run_seen;
		logic             auto_seen;
		logic [VAL_W-1:0] speed_out;
	} ctrl_reg_t;

	ctrl_reg_t state;
	ctrl_reg_t next_state;

	// ----------------------------------------------------------------
	// sleep switch source
	// ----------------------------------------------------------------
	logic [DI_COUNT-1:0]  di_hit;
	logic [EXT_COUNT-1:0] ext_hit;
	logic [CMD_COUNT-1:0] cmd_hit;
	logic [DI_COUNT-1:0]  low_hit;
	logic [CMD_COUNT-1:0] cmd_lane;
	logic                 switch_active;

	assign cmd_lane = COMMAND_BITS[SWITCH_BUS_SELECT % BUS_COUNT * CMD_COUNT +: CMD_COUNT];

	// decode one hot per source entry; unassigned leaves every hit low
	genvar gi;
	generate
		for (gi = 0; gi < CMD_COUNT; gi++) begin : g_src
			if (gi < DI_COUNT) begin : g_di
				assign di_hit[gi]  = (SLEEP_SWITCH_SOURCE == SRC_DI_BASE + SRC_W'(gi))
					& DIGITAL_IN[gi];
				assign low_hit[gi] = (SLEEP_SWITCH_SOURCE == SRC_LOW_BASE + SRC_W'(gi))
					& ~DIGITAL_IN[gi];
			end
			if (gi < EXT_COUNT) begin : g_ext
				assign ext_hit[gi] = (SLEEP_SWITCH_SOURCE == SRC_EXT_BASE + SRC_W'(gi))
					& EXTENSION_IN[gi];
			end
			assign cmd_hit[gi] = (SLEEP_SWITCH_SOURCE == SRC_CMD_BASE + SRC_W'(gi))
				& cmd_lane[gi];
		end
	endgenerate

	assign switch_active = (|di_hit) | (|ext_hit) | (|cmd_hit) | (|low_hit);

	// ----------------------------------------------------------------
	// sleep criteria
	// ----------------------------------------------------------------
	logic flow_low;
	logic speed_low;
	logic power_low;
	logic pressure_high;
	logic sleep_met;
	logic sleep_cond;

	assign flow_low      = PROCESS.flow < LEVELS.flow_level;
	assign speed_low     = PROCESS.speed < LEVELS.speed_level;
	assign power_low     = PROCESS.power < LEVELS.power_level;
	assign pressure_high = PROCESS.pressure > LEVELS.pressure_level;

	always_comb begin
		case (SLEEP_DETECT_SELECT)
			DETECT_SWITCH:   sleep_met = switch_active;
			DETECT_FLOW:     sleep_met = flow_low;
			DETECT_SPEED:    sleep_met = speed_low;
			DETECT_POWER:    sleep_met = power_low;
			DETECT_PRESSURE: sleep_met = pressure_high;
			DETECT_MULTIPLE: sleep_met = (SWITCH_CRITERION & switch_active)
				| (LOW_FLOW_CRITERION & flow_low) | (SPEED_CRITERION & speed_low)
				| (POWER_CRITERION & power_low)
				| (HIGH_PRESSURE_CRITERION & pressure_high);
			default:         sleep_met = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// wake criteria
	// ----------------------------------------------------------------
	logic [VAL_W:0] err_low;
	logic [VAL_W:0] err_high;
	logic           wake_met;

	// one extra bit so reference +/- error cannot wrap around
	assign err_low  = {1'b0, PROCESS.reference} - {1'b0, LEVELS.wake_error};
	assign err_high = {1'b0, PROCESS.reference} + {1'b0, LEVELS.wake_error};

	always_comb begin
		case (WAKE_MODE_SELECT)
			WAKE_FEEDBACK: wake_met = LOOP_INVERSION
				? (PROCESS.feedback > LEVELS.wake_level)
				: (PROCESS.feedback < LEVELS.wake_level);
			WAKE_ERROR:    wake_met = LOOP_INVERSION
				? ({1'b0, PROCESS.feedback} > err_high)
				: (!err_low[VAL_W] && {1'b0, PROCESS.feedback} < err_low);
			WAKE_PRESSURE: wake_met = PROCESS.feedback < LEVELS.wake_level;
			default:       wake_met = 1'b0;
		endcase
	end

	assign sleep_cond = sleep_met & ~wake_met
		& (~MULTI_PUMP | FLOW_CONTROL | AUX_PUMPS_STOPPED);

	// ----------------------------------------------------------------
	// qualification timers
	// ----------------------------------------------------------------
	logic sleep_ok;
	logic wake_ok;

	qualify_timer #(.W(DLY_W)) u_sleep_timer (
		.clk     (MCLK),
		.rst     (RST),
		.ce      (CE),
		.cond    (sleep_cond & (state.mode == ST_RUN)),
		.delay   (SLEEP_QUALIFY_DELAY),
		.expired (sleep_ok)
	);

	qualify_timer #(.W(DLY_W)) u_wake_timer (
		.clk     (MCLK),
		.rst     (RST),
		.ce      (CE),
		.cond    (wake_met & (state.mode == ST_SLEEP)),
		.delay   (WAKE_QUALIFY_DELAY),
		.expired (wake_ok)
	);

	// ----------------------------------------------------------------
	// control sequence
	// ----------------------------------------------------------------
	logic active;
	logic start_edge;

	assign active     = RUN_ORDER & AUTO_MODE;
	assign start_edge = active & ~(state.run_seen & state.auto_seen);

	always_comb begin
		next_state           = state;
		next_state.run_seen  = RUN_ORDER;
		next_state.auto_seen = AUTO_MODE;
		if (!active) begin
			next_state.mode        = ST_IDLE;
			next_state.boost_count = TIMER_RESET;
			next_state.speed_out   = '0;
		end else begin
			case (state.mode)
				ST_IDLE: begin
					if (start_edge && state.auto_seen && !state.run_seen)
						next_state.mode = wake_met ? ST_RUN : ST_SLEEP;
					else if (MOTOR_RUNNING)
						next_state.mode = ST_RUN;
					else
						next_state.mode = wake_met ? ST_RUN : ST_SLEEP;
				end
				ST_RUN: begin
					if (sleep_ok) begin
						if (SLEEP_BOOST_TIME == BOOST_NONE) begin
							next_state.mode = ST_SLEEP;
						end else begin
							next_state.mode        = ST_BOOST;
							next_state.boost_count = TIMER_RESET;
							next_state.speed_out   = SLEEP_BOOST_SPEED;
						end
					end
				end
				ST_BOOST: begin
					if (state.boost_count + 16'h0001 >= SLEEP_BOOST_TIME) begin
						next_state.mode      = ST_SLEEP;
						next_state.speed_out = '0;
					end else begin
						next_state.boost_count = state.boost_count + 16'h0001;
					end
				end
				ST_SLEEP: begin
					if (wake_ok)
						next_state.mode = ST_RUN;
				end
				default: next_state.mode = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST)
			state <= '{mode: ST_IDLE, default: '0};
		else if (CE)
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LOOP_ACTIVE    = state.mode == ST_RUN;
	assign BOOST_ACTIVE   = state.mode == ST_BOOST;
	assign ASLEEP         = state.mode == ST_SLEEP;
	assign MOTOR_STOP     = state.mode == ST_SLEEP;
	assign SPEED_OVERRIDE = state.speed_out;
endmodule
`default_nettype wire

// file: rtl/sleep_wake_pkg.sv
// shared types and constants for the pump sleep/wake controller
`default_nettype none
package sleep_wake_pkg;
	localparam int VAL_W   = 16;
	localparam int DLY_W   = 16;
	localparam int SRC_W   = 6;
	localparam int DI_N    = 6;
	localparam int EXT_N   = 6;
	localparam int CMD_N   = 16;
	localparam int BUS_N   = 5;
	localparam logic [DLY_W-1:0] TIMER_RESET = 16'h0000;
	localparam logic [DLY_W-1:0] BOOST_NONE  = 16'h0000;
	localparam logic [SRC_W-1:0] SRC_NONE    = 6'h00;
	localparam logic [SRC_W-1:0] SRC_DI_BASE = 6'h01;
	localparam logic [SRC_W-1:0] SRC_EXT_BASE = 6'h07;
	localparam logic [SRC_W-1:0] SRC_CMD_BASE = 6'h0D;
	localparam logic [SRC_W-1:0] SRC_LOW_BASE = 6'h1D;

	typedef enum logic [2:0] {
		DETECT_NONE, DETECT_SWITCH, DETECT_FLOW, DETECT_SPEED,
		DETECT_POWER, DETECT_PRESSURE, DETECT_MULTIPLE
	} sleep_detect_t;

	typedef enum logic [1:0] {
		WAKE_FEEDBACK, WAKE_ERROR, WAKE_PRESSURE
	} wake_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_RUN, ST_BOOST, ST_SLEEP
	} ctrl_state_t;

	typedef struct packed {
		logic [VAL_W-1:0] flow;
		logic [VAL_W-1:0] pressure;
		logic [VAL_W-1:0] speed;
		logic [VAL_W-1:0] power;
		logic [VAL_W-1:0] feedback;
		logic [VAL_W-1:0] reference;
	} process_t;

	typedef struct packed {
		logic [VAL_W-1:0] flow_level;
		logic [VAL_W-1:0] pressure_level;
		logic [VAL_W-1:0] speed_level;
		logic [VAL_W-1:0] power_level;
		logic [VAL_W-1:0] wake_level;
		logic [VAL_W-1:0] wake_error;
	} levels_t;

	typedef struct packed {
		logic [DLY_W-1:0] count;
		logic             done;
	} timer_t;
endpackage
`default_nettype wire
